// file: rtl/adcc_pkg.sv
// Constants, register map and carrier types of the converter control block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
// Functional notes
// - Configuration bit 7 selects low-power, slower converter clock
// - Configuration bits 6:5 divide input clock; 00 is one
// - Configuration bit 4: sample 3.5 or 23.5 cycles
// - Configuration bits 3:2 pick resolution; 10 is 10-bit
// - Configuration bits 1:0 pick source; 00 is bus clock
// - Control two bit 7 reads one while converting
// - Control two: bit 6 hardware trigger, bit 5 compare
// - Control two bits 3:2 always read zero
// - Control one bit 7 read-only completion flag
// - Control one bit 6 enables completion interrupt request
// - Control one bit 5 continuous, else one per trigger
// - Control one bits 4:0 select the input channel
// - High byte read blocks overwrite until low read
// - Compare value pair holds compare threshold
// - Pin-control bit set disables that pin's digital control
// - Conversions allowed whatever the pin-control bit
// - Pin-control bit set: output high-impedance, pullup off
// - Input beyond references saturates to full scale or zero
// - With compare, flag only when compare condition holds
package adcc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_SC2 = 8'h04;
  localparam logic [7:0] OFF_SC1 = 8'h08;
  localparam logic [7:0] OFF_RH = 8'h0C;
  localparam logic [7:0] OFF_RL = 8'h10;
  localparam logic [7:0] OFF_CVH = 8'h14;
  localparam logic [7:0] OFF_CVL = 8'h18;
  localparam logic [7:0] OFF_PC1 = 8'h1C;
  localparam logic [7:0] OFF_PC2 = 8'h20;

  // Reset values
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_SC2 = 8'h00;
  localparam logic [7:0] RST_SC1 = 8'h00;
  localparam logic [9:0] RST_CV = 10'h000;
  localparam logic [9:0] RST_RES = 10'h000;
  localparam logic [7:0] RST_PC = 8'h00;

  // Field encodings
  localparam logic [1:0] MODE_10BIT = 2'b10;
  localparam logic [1:0] ICLK_BUS = 2'b00;
  localparam logic [1:0] ICLK_HALF = 2'b01;
  localparam logic [1:0] ICLK_ALT = 2'b10;
  localparam logic [1:0] ICLK_ASYNC = 2'b11;
  localparam logic [1:0] DIV_ONE = 2'b00;

  // Sample windows in half converter cycles, rounded up to whole ticks
  localparam int SAMPLE_SHORT_HALF = 7;
  localparam int SAMPLE_LONG_HALF = 47;
  localparam logic [5:0] SAMPLE_SHORT_TICKS = 6'((SAMPLE_SHORT_HALF + 1) / 2);
  localparam logic [5:0] SAMPLE_LONG_TICKS = 6'((SAMPLE_LONG_HALF + 1) / 2);

  localparam int RES_BITS = 10;
  localparam int PIN_COUNT = 16;

  // Configuration register layout, bit 7 first
  typedef struct packed {
    logic low_power_select;
    logic [1:0] clock_divide_select;
    logic long_sample_select;
    logic [1:0] mode_select;
    logic [1:0] input_clock_select;
  } adcc_cfg_t;

  // Control two layout
  typedef struct packed {
    logic conversion_active_flag;
    logic trigger_select;
    logic compare_enable;
    logic compare_greater_select;
    logic [1:0] unused;
    logic [1:0] internal;
  } adcc_sc2_t;

  // Control one layout
  typedef struct packed {
    logic conversion_complete_flag;
    logic completion_interrupt_enable;
    logic continuous_conversion_enable;
    logic [4:0] channel_select;
  } adcc_sc1_t;

  // Wishbone request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } adcc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } adcc_wb_rsp_t;

  // Conversion phases, Gray along idle, sample, convert, finish
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_CONVERT = 2'b11,
    PH_FINISH = 2'b10
  } adcc_phase_t;

endpackage

// file: rtl/adcc_clkgen.sv
// Converter clock enable generator: source select, divider, low-power limit.
// Assumes alt_clock comes from a pin of another domain; tick is a bus-clock enable.
`timescale 1ns/1ns
`default_nettype none
module adcc_clkgen
  import adcc_pkg::*;
#(
  parameter int ASYNC_DIV = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Configuration
  input wire adcc_cfg_t cfg,
  // Alternate clock pin
  input wire logic alt_clock,
  // Converter clock enable
  output logic tick
);

  typedef struct packed {
    logic alt_s1;
    logic alt_s2;
    logic alt_s3;
    logic half;
    logic [7:0] async_cnt;
    logic [2:0] div_cnt;
    logic tick;
  } adcc_clk_state_t;

  adcc_clk_state_t q;
  adcc_clk_state_t s;
  logic src_en;
  logic [2:0] div_last;
  logic fire;

  // Source select, divider and low-power gap
  always_comb begin
    s = q;
    s.alt_s1 = alt_clock;
    s.alt_s2 = q.alt_s1;
    s.alt_s3 = q.alt_s2;
    s.half = ~q.half;
    s.async_cnt = (q.async_cnt == 8'(ASYNC_DIV - 1)) ? 8'h00 : q.async_cnt + 8'h01;
    unique case (cfg.input_clock_select)
      ICLK_BUS: src_en = 1'b1;
      ICLK_HALF: src_en = q.half;
      ICLK_ALT: src_en = q.alt_s2 & ~q.alt_s3;
      ICLK_ASYNC: src_en = (q.async_cnt == 8'h00);
    endcase
    div_last = 3'((4'h1 << cfg.clock_divide_select) - 4'h1);
    fire = 1'b0;
    if (src_en) begin
      if (q.div_cnt >= div_last) begin
        s.div_cnt = 3'h0;
        fire = 1'b1;
      end else begin
        s.div_cnt = q.div_cnt + 3'h1;
      end
    end
    // Low power never lets two ticks run back to back
    s.tick = fire & ~(cfg.low_power_select & q.tick);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign tick = q.tick;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_divide_by_one: assert property (
    (cfg.input_clock_select == ICLK_BUS && cfg.clock_divide_select == DIV_ONE && !cfg.low_power_select)[*2]
    |=> q.tick) else $error("divide by one from bus clock did not tick every cycle");

  a_low_power_gap: assert property (
    (q.tick && cfg.low_power_select) |=> !q.tick) else $error("low power allowed back to back ticks");

endmodule
`default_nettype wire

// file: rtl/adcc_top.sv
// Converter control front end: Wishbone registers, conversion sequencer,
// compare, result blocking and analog pin control.
// Assumes the analog core answers comparator_above for dac_code in the same clock domain.
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module adcc_top
  import adcc_pkg::*;
#(
  parameter int ASYNC_DIV = 4,
  parameter int PINS = PIN_COUNT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire adcc_wb_req_t wb_req,
  output adcc_wb_rsp_t wb_rsp,
  // Clock and trigger pins
  input wire logic alt_clock,
  input wire logic hw_trigger,
  // Analog core
  input wire logic comparator_above,
  output logic [RES_BITS-1:0] dac_code,
  output logic sample_en,
  output logic [4:0] channel,
  // Completion request
  output logic irq,
  // Port logic and pads
  input wire logic [PINS-1:0] gpio_out_en,
  input wire logic [PINS-1:0] gpio_pullup,
  output logic [PINS-1:0] pad_out_en,
  output logic [PINS-1:0] pad_pullup_en,
  output logic [PINS-1:0] pin_input_disable
);

  typedef struct packed {
    adcc_wb_rsp_t rsp;
    adcc_cfg_t cfg;
    adcc_sc2_t sc2;
    adcc_sc1_t sc1;
    logic [9:0] cv;
    logic [9:0] res;
    logic [7:0] pc1;
    logic [7:0] pc2;
    logic block;
    adcc_phase_t phase;
    logic [5:0] cnt;
    logic [3:0] bit_idx;
    logic [9:0] dac;
    logic sample;
    logic irq;
    logic trg_s1;
    logic trg_s2;
    logic trg_s3;
    logic [PINS-1:0] pad_oe;
    logic [PINS-1:0] pad_pu;
  } adcc_state_t;

  adcc_state_t q;
  adcc_state_t s;
  logic tick;
  logic req;
  logic acc;
  logic wr;
  logic rd;
  logic sc1_wr;
  logic start;
  logic hw_edge;
  logic rh_pending;
  logic [10:0] diff;
  logic cmp_ok;
  logic [5:0] samp_ticks;
  logic [3:0] top_bit;
  logic [PINS-1:0] pctl;

  // Decode a byte address against a register offset
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = ({adr[7:2], 2'b00} == off);
  endfunction

  // Read value of a register, zero for unmapped words
  function automatic logic [7:0] read_mux(input adcc_state_t st, input logic [7:0] adr);
    read_mux = 8'h00;
    if (hit(adr, OFF_CFG)) read_mux = st.cfg;
    if (hit(adr, OFF_SC2)) read_mux = {st.sc2[7:4], 4'h0};
    if (hit(adr, OFF_SC1)) read_mux = st.sc1;
    if (hit(adr, OFF_RH)) read_mux = {6'h00, st.res[9:8]};
    if (hit(adr, OFF_RL)) read_mux = st.res[7:0];
    if (hit(adr, OFF_CVH)) read_mux = {6'h00, st.cv[9:8]};
    if (hit(adr, OFF_CVL)) read_mux = st.cv[7:0];
    if (hit(adr, OFF_PC1)) read_mux = st.pc1;
    if (hit(adr, OFF_PC2)) read_mux = st.pc2;
  endfunction

  adcc_clkgen #(
    .ASYNC_DIV(ASYNC_DIV)
  ) u_clkgen (
    .clock(clock),
    .rst(rst),
    .cfg(q.cfg),
    .alt_clock(alt_clock),
    .tick(tick)
  );

  // Bus handshake terms; the write lands on the edge that carries ack
  always_comb begin
    req = wb_req.cyc & wb_req.stb;
    acc = req & q.rsp.ack;
    wr = acc & wb_req.we & wb_req.sel[0];
    rd = acc & ~wb_req.we;
    sc1_wr = wr & hit(wb_req.adr, OFF_SC1);
    // A high-byte read in flight already counts as blocking
    rh_pending = req & ~wb_req.we & hit(wb_req.adr, OFF_RH);
    hw_edge = q.trg_s2 & ~q.trg_s3;
    start = (sc1_wr & ~q.sc2.trigger_select)
      | (q.sc2.trigger_select & hw_edge & (q.phase == PH_IDLE));
    samp_ticks = q.cfg.long_sample_select ? SAMPLE_LONG_TICKS : SAMPLE_SHORT_TICKS;
    top_bit = (q.cfg.mode_select == MODE_10BIT) ? 4'd9 : 4'd7;
    diff = {1'b0, q.dac} - {1'b0, q.cv};
    // Upper limit: result at or above; lower limit: result below
    cmp_ok = q.sc2.compare_greater_select ? ~diff[10] : diff[10];
    pctl = PINS'({q.pc2, q.pc1});
  end

  // Next state of registers and sequencer
  always_comb begin
    s = q;
    s.rsp.ack = req & ~q.rsp.ack;
    s.rsp.dat = {24'h000000, read_mux(q, wb_req.adr)};
    s.trg_s1 = hw_trigger;
    s.trg_s2 = q.trg_s1;
    s.trg_s3 = q.trg_s2;

    // Register writes; result and flag bits are not writable
    if (wr) begin
      if (hit(wb_req.adr, OFF_CFG)) s.cfg = wb_req.dat[7:0];
      if (hit(wb_req.adr, OFF_SC2)) begin
        s.sc2.trigger_select = wb_req.dat[6];
        s.sc2.compare_enable = wb_req.dat[5];
        s.sc2.compare_greater_select = wb_req.dat[4];
        s.sc2.internal = wb_req.dat[1:0];
      end
      if (hit(wb_req.adr, OFF_SC1)) begin
        s.sc1.completion_interrupt_enable = wb_req.dat[6];
        s.sc1.continuous_conversion_enable = wb_req.dat[5];
        s.sc1.channel_select = wb_req.dat[4:0];
        s.sc1.conversion_complete_flag = 1'b0;
      end
      if (hit(wb_req.adr, OFF_CVH)) s.cv[9:8] = wb_req.dat[1:0];
      if (hit(wb_req.adr, OFF_CVL)) s.cv[7:0] = wb_req.dat[7:0];
      if (hit(wb_req.adr, OFF_PC1)) s.pc1 = wb_req.dat[7:0];
      if (hit(wb_req.adr, OFF_PC2)) s.pc2 = wb_req.dat[7:0];
    end

    // Result read order: high sets the block, low releases it
    if (rd && hit(wb_req.adr, OFF_RH)) s.block = 1'b1;
    if (rd && hit(wb_req.adr, OFF_RL)) begin
      s.block = 1'b0;
      s.sc1.conversion_complete_flag = 1'b0;
    end

    // Sequencer; pin control never gates a conversion
    unique case (q.phase)
      PH_IDLE: begin
        s.sample = 1'b0;
      end
      PH_SAMPLE: begin
        if (tick) begin
          if (q.cnt >= samp_ticks - 6'd1) begin
            s.phase = PH_CONVERT;
            s.sample = 1'b0;
            s.bit_idx = top_bit;
            s.dac = 10'(10'h001 << top_bit);
          end else begin
            s.cnt = q.cnt + 6'd1;
          end
        end
      end
      PH_CONVERT: begin
        if (tick) begin
          // Comparator always high ends at all ones, always low at zero
          if (!comparator_above) s.dac[q.bit_idx] = 1'b0;
          if (q.bit_idx == 4'd0) begin
            s.phase = PH_FINISH;
          end else begin
            s.bit_idx = q.bit_idx - 4'd1;
            s.dac[q.bit_idx - 4'd1] = 1'b1;
          end
        end
      end
      PH_FINISH: begin
        // Blocked or failed compare drops the result and leaves the flag alone
        if (!q.block && !rh_pending && (!q.sc2.compare_enable || cmp_ok)) begin
          s.res = q.sc2.compare_enable ? diff[9:0] : q.dac;
          s.sc1.conversion_complete_flag = 1'b1;
        end
        if (q.sc1.continuous_conversion_enable) begin
          s.phase = PH_SAMPLE;
          s.sample = 1'b1;
          s.cnt = 6'd0;
        end else begin
          s.phase = PH_IDLE;
        end
      end
    endcase

    // Any control-one write aborts; a software trigger restarts
    if (sc1_wr) begin
      s.phase = PH_IDLE;
      s.sample = 1'b0;
    end
    if (start) begin
      s.phase = PH_SAMPLE;
      s.sample = 1'b1;
      s.cnt = 6'd0;
      s.dac = 10'h000;
    end

    s.sc2.conversion_active_flag = (s.phase != PH_IDLE);
    s.sc2.unused = 2'b00;
    s.irq = s.sc1.conversion_complete_flag & s.sc1.completion_interrupt_enable;
    // Analog pins lose output drive and pullup
    s.pad_oe = gpio_out_en & ~pctl;
    s.pad_pu = gpio_pullup & ~pctl;
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
      q.cfg <= RST_CFG;
      q.sc2 <= RST_SC2;
      q.sc1 <= RST_SC1;
      q.cv <= RST_CV;
      q.res <= RST_RES;
      q.pc1 <= RST_PC;
      q.pc2 <= RST_PC;
      q.phase <= PH_IDLE;
    end else begin
      q <= s;
    end
  end

  // Outputs straight from the state register
  assign wb_rsp = q.rsp;
  assign dac_code = q.dac;
  assign sample_en = q.sample;
  assign channel = q.sc1.channel_select;
  assign irq = q.irq;
  assign pad_out_en = q.pad_oe;
  assign pad_pullup_en = q.pad_pu;
  assign pin_input_disable = {q.pc2, q.pc1};

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Status flags and register read-back
  a_active_while_busy: assert property (
    (q.sample || q.phase == PH_CONVERT) |-> q.sc2.conversion_active_flag)
    else $error("active flag low during a conversion");

  a_unused_read_zero: assert property (
    (q.rsp.ack && hit($past(wb_req.adr), OFF_SC2)) |-> q.rsp.dat[3:2] == 2'b00)
    else $error("unimplemented control two bits read nonzero");

  a_flag_from_finish: assert property (
    $rose(q.sc1.conversion_complete_flag) |-> $past(q.phase) == PH_FINISH)
    else $error("completion flag set outside finish");

  // Request is registered together with the flag, so no delay between them
  a_irq_needs_enable: assert property (
    q.irq == (q.sc1.completion_interrupt_enable && q.sc1.conversion_complete_flag))
    else $error("completion request does not follow enable and flag");

  // Sequencer and result path
  a_single_stops: assert property (
    (q.phase == PH_FINISH && !q.sc1.continuous_conversion_enable && !start) |=> q.phase == PH_IDLE)
    else $error("single conversion did not return to idle");

  // A low-byte read may still clear the flag in the same cycle
  a_block_holds: assert property (
    (q.block && q.phase == PH_FINISH) |=> $stable(q.res) && !$rose(q.sc1.conversion_complete_flag))
    else $error("blocked result was overwritten");

  a_compare_fail_quiet: assert property (
    (q.phase == PH_FINISH && q.sc2.compare_enable && !cmp_ok && !q.sc1.conversion_complete_flag && !sc1_wr)
    |=> !q.sc1.conversion_complete_flag) else $error("flag set with compare condition false");

  a_sw_restart: assert property (
    (sc1_wr && !q.sc2.trigger_select) |=> q.phase == PH_SAMPLE && q.sample && q.cnt == 6'd0)
    else $error("software trigger write did not restart sampling");

  // Short window: four whole ticks at the bus rate, unless a write cuts it
  a_short_sample: assert property (
    ($rose(q.sample) && $stable(q.cfg) && !q.cfg.long_sample_select && q.cfg.input_clock_select == ICLK_BUS
      && q.cfg.clock_divide_select == DIV_ONE && !q.cfg.low_power_select && !wr ##1 (!wr)[*3])
    |-> (q.sample && $past(q.sample) && $past(q.sample, 2) && $past(q.sample, 3)) ##1 !q.sample)
    else $error("short sample window length wrong");

  // Pad control; one cycle behind the register
  a_pin_drive_off: assert property (
    q.pc1[1] |=> !q.pad_oe[1] && !q.pad_pu[1]) else $error("analog pin kept drive or pullup");

  // Ack is a one-cycle pulse; a request still held after it is answered again two cycles later
  a_ack_single_pulse: assert property (
    q.rsp.ack |=> !q.rsp.ack) else $error("ack stood for more than one cycle");

  // A fresh request is answered on the next edge
  a_ack_next_edge: assert property (
    (req && !q.rsp.ack) |=> q.rsp.ack) else $error("request not answered on the next edge");

  // Software cannot set the completion flag through a write
  a_flag_read_only: assert property (
    (sc1_wr && q.phase != PH_FINISH) |=> !q.sc1.conversion_complete_flag)
    else $error("control one write left the completion flag set");

  // A high-byte read arms the overwrite block
  a_high_read_blocks: assert property (
    (rd && hit(wb_req.adr, OFF_RH)) |=> q.block) else $error("high byte read did not block the result");

  // With hardware trigger a control-one write only aborts
  a_hw_mode_no_start: assert property (
    (sc1_wr && q.sc2.trigger_select && !start) |=> q.phase == PH_IDLE && !q.sample)
    else $error("control one write started a conversion in hardware trigger mode");

  // Edges during an approximation never restart sampling
  a_busy_ignores_edge: assert property (
    (q.sc2.trigger_select && q.phase == PH_CONVERT && !sc1_wr) |=> q.phase != PH_SAMPLE)
    else $error("trigger restarted a conversion in progress");

  // Eight-bit conversions never touch the top two code bits
  a_eight_bit_code: assert property (
    (q.phase == PH_FINISH && q.cfg.mode_select != MODE_10BIT) |-> q.dac[9:8] == 2'b00)
    else $error("eight-bit conversion produced a ten-bit code");

  // Continuous mode resamples straight after finish
  a_continuous_again: assert property (
    (q.phase == PH_FINISH && q.sc1.continuous_conversion_enable && !sc1_wr) |=> q.phase == PH_SAMPLE && q.sample)
    else $error("continuous mode did not start the next sample");

endmodule
`default_nettype wire

// file: verif/adcc_analog_model.sv
// Behavioural analog core: sample-and-hold plus comparator against the trial code.
// Assumes level is an 11-bit input scale where 10'h3FF and above reach the high reference.
`timescale 1ns/1ns
`default_nettype none
module adcc_analog_model (
  // Clock
  input wire logic clock,
  // Sampling and mode
  input wire logic sample_en,
  input wire logic eight_bit,
  input wire logic [10:0] level,
  // Comparator
  input wire logic [9:0] dac_code,
  output logic comparator_above
);
  logic [10:0] held = 11'h000;

  // Input tracked only in the window, frozen for the approximation
  always_ff @(posedge clock) begin
    if (sample_en) begin
      held <= level;
    end
  end

  // Extra headroom bit makes inputs beyond the reference saturate
  assign comparator_above = eight_bit ? ({1'b0, held[10:2]} >= {2'b00, dac_code[7:0]})
                                      : (held >= {1'b0, dac_code});
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the converter control front end over Wishbone.
// Assumes the register offsets of adcc_pkg and a one-cycle ack.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  import adcc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hw_trigger = 1'b0;
  logic alt_clock = 1'b0;
  logic eight_bit = 1'b0;
  logic above, sample_en, irq;
  logic [15:0] gpio_out_en = 16'hFFFF;
  logic [15:0] gpio_pullup = 16'hFFFF;
  logic [15:0] pad_oe, pad_pu, pin_dis;
  logic [10:0] level = 11'h000;
  logic [9:0] dac, r;
  logic [4:0] channel;
  logic [7:0] q;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int scnt = 0;
  int slen = 0;
  adcc_wb_req_t wb_req = '0;
  adcc_wb_rsp_t wb_rsp;
  logic [7:0] tc[9] = '{8'h08, 8'h08, 8'h00, 8'h18, 8'h98, 8'h28, 8'h09, 8'h0A, 8'h0B};
  logic [10:0] tl[9] = '{11'h7FF, 11'h000, 11'h7FF, 11'h155, 11'h0AA, 11'h123, 11'h321, 11'h2F0, 11'h10F};
  logic [9:0] tr[9] = '{10'h3FF, 10'h000, 10'h0FF, 10'h155, 10'h0AA, 10'h123, 10'h321, 10'h2F0, 10'h10F};
  int ts[9] = '{4, 4, 4, 24, 7, 7, 7, 7, 7};

  always #5 clock = ~clock;

  // Alternate converter clock pin at half the bus rate
  always @(posedge clock) alt_clock <= ~alt_clock;

  adcc_top #(.ASYNC_DIV(2)) adcc_top_inst (.clock(clock), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .alt_clock(alt_clock), .hw_trigger(hw_trigger), .comparator_above(above), .dac_code(dac),
    .sample_en(sample_en), .channel(channel), .irq(irq), .gpio_out_en(gpio_out_en),
    .gpio_pullup(gpio_pullup), .pad_out_en(pad_oe), .pad_pullup_en(pad_pu), .pin_input_disable(pin_dis));

  adcc_analog_model adcc_analog_model_inst (.clock(clock), .sample_en(sample_en), .eight_bit(eight_bit),
    .level(level), .dac_code(dac), .comparator_above(above));

  task stop_test;
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard and sample window length
  always @(posedge clock) begin
    cycles++;
    if (sample_en === 1'b1) begin
      scnt++;
    end else if (scnt != 0) begin
      slen = scnt;
      scnt = 0;
    end
    if (cycles > 20000) begin
      failures++;
      stop_test();
    end
  end

  // One classic cycle, held until ack, then a low cycle
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: {24'h000000, d}};
    do @(posedge clock); while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat[7:0];
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clock);
  endtask

  task waitdone;
    q = 8'h00;
    while (q[7] !== 1'b1) xfer(1'b0, OFF_SC1, 8'h00);
  endtask

  // High byte first so the pair cannot be overwritten
  task getres;
    xfer(1'b0, OFF_RH, 8'h00);
    r[9:8] = q[1:0];
    xfer(1'b0, OFF_RL, 8'h00);
    r[7:0] = q;
  endtask

  // Configuration, then control two, then control one
  task conv(input logic [7:0] cfg, input logic [7:0] sc2, input logic [7:0] sc1, input logic [10:0] lv);
    level <= lv;
    eight_bit <= (cfg[3:2] != MODE_10BIT);
    xfer(1'b1, OFF_CFG, cfg);
    xfer(1'b1, OFF_SC2, sc2);
    xfer(1'b1, OFF_SC1, sc1);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    xfer(1'b1, OFF_RH, 8'hFF);
    xfer(1'b1, 8'h24, 8'h5A);
    for (int i = 0; i <= 9; i++) begin
      xfer(1'b0, 8'(i * 4), 8'h00);
      `CHK("reset or read-only", 8'h00, q)
    end
    xfer(1'b1, OFF_PC1, 8'h02);
    xfer(1'b1, OFF_PC2, 8'h00);
    `CHK("pin_dis", 16'h0002, pin_dis)
    `CHK("pad_oe", 16'hFFFD, pad_oe)
    `CHK("pad_pu", 16'hFFFD, pad_pu)
    conv(8'h08, 8'h00, 8'h41, 11'h2A5);
    xfer(1'b0, OFF_SC2, 8'h00);
    `CHK("active", 1'b1, q[7])
    `CHK("channel", 5'd1, channel)
    waitdone();
    `CHK("irq", 1'b1, irq)
    getres();
    `CHK("result", 10'h2A5, r)
    xfer(1'b0, OFF_SC1, 8'h00);
    `CHK("flag clear", 8'h41, q)
    `CHK("irq clear", 1'b0, irq)
    // Resolution, saturation, window length, low power, divider and clock sources
    for (int i = 0; i < 9; i++) begin
      conv(tc[i], 8'h00, 8'h02, tl[i]);
      waitdone();
      getres();
      `CHK("table result", tr[i], r)
      `CHK("sample len", ts[i], (((tc[i] & 8'hE3) != 8'h00) && slen >= 7) ? 7 : slen)
    end
    `CHK("channel two", 5'd2, channel)
    // Continuous with the pair held by a high-byte read
    conv(8'h08, 8'h00, 8'h22, 11'h155);
    waitdone();
    xfer(1'b0, OFF_RH, 8'h00);
    `CHK("held high", 8'h01, q)
    level <= 11'h2AA;
    repeat (60) @(posedge clock);
    xfer(1'b0, OFF_RL, 8'h00);
    `CHK("held low", 8'h55, q)
    waitdone();
    getres();
    `CHK("continuous", 10'h2AA, r)
    // Restart in mid-conversion
    conv(8'h08, 8'h00, 8'h02, 11'h111);
    repeat (8) @(posedge clock);
    level <= 11'h222;
    xfer(1'b1, OFF_SC1, 8'h02);
    waitdone();
    getres();
    `CHK("restart", 10'h222, r)
    // Compare, upper and lower limit
    xfer(1'b1, OFF_CVH, 8'h01);
    xfer(1'b1, OFF_CVL, 8'h00);
    conv(8'h08, 8'h30, 8'h02, 11'h180);
    waitdone();
    getres();
    `CHK("cmp ge", 10'h080, r)
    conv(8'h08, 8'h30, 8'h02, 11'h080);
    repeat (40) @(posedge clock);
    xfer(1'b0, OFF_SC1, 8'h00);
    `CHK("cmp miss", 1'b0, q[7])
    getres();
    `CHK("cmp keep", 10'h080, r)
    conv(8'h08, 8'h20, 8'h02, 11'h080);
    waitdone();
    getres();
    `CHK("cmp lt", 10'h380, r)
    // Hardware trigger; control one write alone must not start
    conv(8'h08, 8'h4C, 8'h02, 11'h0F0);
    xfer(1'b0, OFF_SC2, 8'h00);
    `CHK("sc2 read", 8'h40, q)
    repeat (40) @(posedge clock);
    xfer(1'b0, OFF_SC1, 8'h00);
    `CHK("no sw start", 1'b0, q[7])
    hw_trigger <= 1'b1;
    repeat (4) @(posedge clock);
    hw_trigger <= 1'b0;
    waitdone();
    getres();
    `CHK("hw result", 10'h0F0, r)
    stop_test();
  end
endmodule
`default_nettype wire
